// >>> verilog/fspc_pkg.sv
// Constants, register map and state codes of the flash self-programming controller
package fspc_pkg;

	// Register byte offsets on the APB bus, and the control register reset value
	localparam logic [7:0] FSPC_CTRL_OFFS = 8'h00;
	localparam logic [7:0] FSPC_STAT_OFFS = 8'h04;
	localparam logic [7:0] FSPC_CTRL_RESET = 8'h00;

	// Control register field positions
	localparam int FSPC_EN_BIT = 0;
	localparam int FSPC_ERS_BIT = 1;
	localparam int FSPC_WRT_BIT = 2;
	localparam int FSPC_RFL_BIT = 3;
	localparam int FSPC_CLR_BIT = 4;

	// Status register field positions
	localparam int FSPC_STAT_BUSY_BIT = 0;
	localparam int FSPC_STAT_BUFD_BIT = 1;
	localparam int FSPC_STAT_ARM_BIT = 2;

	// The only command patterns that change the control register
	localparam logic [4:0] FSPC_CMD_CLEAR = 5'h11;
	localparam logic [4:0] FSPC_CMD_RDFUSE = 5'h09;
	localparam logic [4:0] FSPC_CMD_WRITE = 5'h05;
	localparam logic [4:0] FSPC_CMD_ERASE = 5'h03;
	localparam logic [4:0] FSPC_CMD_LOAD = 5'h01;

	// Arming windows in core clock cycles
	localparam int FSPC_STORE_WIN = 4;
	localparam int FSPC_LOAD_WIN = 3;

	// Erase and write time: least time, rounded up at the core clock rate
	localparam int FSPC_CLK_MHZ = 40;
	localparam int FSPC_PROG_MIN_US = 3700;
	localparam int FSPC_PROG_MAX_US = 4500;
	localparam int FSPC_PROG_CYCLES = FSPC_PROG_MIN_US * FSPC_CLK_MHZ;
	localparam int FSPC_TIMER_W = 18;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		FSPC_IDLE = 3'b001,
		FSPC_ERASE = 3'b010,
		FSPC_WRITE = 3'b100
	} fspc_state_t;

endpackage : fspc_pkg

// >>> verilog/fspc_window.sv
// Arming window: stays active a fixed number of cycles after start
`timescale 1ns/1ps
module fspc_window import fspc_pkg::*; #(
	parameter int LEN = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// Control
	input wire logic start,
	input wire logic cancel,
	// Status
	output logic active
);
	typedef struct packed {
		logic [3:0] cnt;
		logic active;
	} fspc_win_t;

	fspc_win_t st_ff;
	fspc_win_t nxt_st;

	// Start reloads; cancel or running out ends the window
	always_comb begin
		nxt_st = st_ff;
		if (start) begin
			nxt_st.cnt = 4'(LEN - 1);
			nxt_st.active = 1'b1;
		end else if (cancel || st_ff.cnt == 4'h0) begin
			nxt_st.cnt = 4'h0;
			nxt_st.active = 1'b0;
		end else begin
			nxt_st.cnt = st_ff.cnt - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign active = st_ff.active;
endmodule : fspc_window

// >>> verilog/fspc_page_buf.sv
// Temporary page buffer with per-word valid flags
`timescale 1ns/1ps
module fspc_page_buf import fspc_pkg::*; #(
	parameter int WORD_BITS = 5,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// Load and clear
	input wire logic clear,
	input wire logic we,
	input wire logic [WORD_BITS-1:0] waddr,
	input wire logic [DATA_W-1:0] wdata,
	// Read side
	input wire logic [WORD_BITS-1:0] raddr,
	output logic [DATA_W-1:0] rdata,
	output logic any_valid
);
	localparam int WORDS = 1 << WORD_BITS;

	typedef struct packed {
		logic [WORDS-1:0] valid;
	} fspc_buf_t;

	fspc_buf_t st_ff;
	fspc_buf_t nxt_st;
	logic [DATA_W-1:0] mem [WORDS];

	// A word already loaded is kept; a second load before a clear is dropped
	always_comb begin
		nxt_st = st_ff;
		if (clear) begin
			nxt_st.valid = '0;
		end else if (we) begin
			nxt_st.valid[waddr] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Storage has no reset; the valid flags decide what it holds
	always_ff @(posedge clk) begin
		if (we && !clear && !st_ff.valid[waddr]) begin
			mem[waddr] <= wdata;
		end
	end

	// Erased words read as all ones
	assign rdata = st_ff.valid[raddr] ? mem[raddr] : {DATA_W{1'b1}};
	assign any_valid = |st_ff.valid;
endmodule : fspc_page_buf

// >>> verilog/fspc_ctrl.sv
// Flash self-programming controller: command arming, page buffer, erase and write sequencer
// Functional notes
// [R1] Software erases a page before writing it; buffer fill may precede or follow erase.
// [R2] Command 00000011 plus store instruction within four cycles erases the pointer's page.
// [R3] Core stays stalled for the whole page erase.
// [R4] Command 00000001 plus store instruction loads data pair at the pointer's word.
// [R5] Buffer clears after page write, on clear-buffer command and on reset.
// [R6] Software loads each buffer word once between clears.
// [R7] An EEPROM write during buffer loading discards all loaded words.
// [R8] Command 00000101 plus store instruction writes the page; data pair ignored.
// [R9] Core stays stalled for the whole page write from the buffer.
// [R10] Pointer splits into word-in-page low bits and page high bits.
// [R11] Software uses the same page address for erase and following write.
// [R12] Buffer words load in any order.
// [R13] Load-program read uses pointer bit 0 to pick high or low byte.
// [R14] Control bits 7 to 5 read as zero.
// [R15] Clear-buffer command discards every loaded word.
// [R16] Fuse/lock read armed by bit 3 with enable, within three cycles.
// [R17] Bit 2 with enable makes next store within four cycles a page write.
// [R18] Write bit clears at write end or after four cycles without store.
// [R19] Bit 1 with enable makes next store within four cycles a page erase.
// [R20] Erase bit clears at erase end or after four cycles without store.
// [R21] Enable arms four cycles; stays set until erase or write completes.
// [R22] Only the five listed low-bit patterns have any effect when written.
// [R23] Erase and write last between 3.7 ms and 4.5 ms.
// [R24] Stall release and command bit clear happen in the same cycle.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module fspc_ctrl import fspc_pkg::*; #(
	parameter int WORD_BITS = 5,
	parameter int PROG_CYCLES = FSPC_PROG_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core instruction side
	input wire logic store_program_instr,
	input wire logic load_program_instr,
	input wire logic [15:0] pointer,
	input wire logic [15:0] data_register_pair,
	input wire logic [15:0] flash_rd_word,
	output logic [7:0] load_data,
	output logic load_valid,
	output logic core_stall,
	// Fuse and lock sources, EEPROM activity
	input wire logic [7:0] lock_bits,
	input wire logic [7:0] fuse_low,
	input wire logic [7:0] fuse_high,
	input wire logic eeprom_busy,
	// Flash array side
	output logic [15-WORD_BITS-1:0] flash_page,
	output logic flash_erase_start,
	output logic flash_prog_we,
	output logic [WORD_BITS-1:0] flash_prog_word,
	output logic [15:0] flash_prog_data
);
	localparam int PAGE_W = 15 - WORD_BITS;
	localparam int WORDS = 1 << WORD_BITS;

	typedef struct packed {
		fspc_state_t state;
		logic [4:0] ctrl;
		logic [PAGE_W-1:0] page;
		logic [FSPC_TIMER_W-1:0] timer;
		logic [WORD_BITS:0] stream;
		logic stall;
		logic erase_go;
		logic prog_we;
		logic [WORD_BITS-1:0] prog_word;
		logic [15:0] prog_data;
		logic [7:0] load_data;
		logic load_valid;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fspc_ctrl_st_t;

	fspc_ctrl_st_t st_ff;
	fspc_ctrl_st_t nxt_st;

	// Reset release chain
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Bus decode; a write takes effect on the edge where pready is seen high
	logic bus_done;
	logic ctrl_hit;
	logic stat_hit;
	logic ctrl_wr;
	logic cmd_legal;
	logic idle;

	assign bus_done = psel && penable && st_ff.pready;
	assign ctrl_hit = paddr == FSPC_CTRL_OFFS;
	assign stat_hit = paddr == FSPC_STAT_OFFS;
	assign idle = st_ff.state == FSPC_IDLE;

	// Only five patterns count; bits 31 to 5 of the written value are ignored
	always_comb begin
		unique case (pwdata[4:0])
			FSPC_CMD_CLEAR, FSPC_CMD_RDFUSE, FSPC_CMD_WRITE, FSPC_CMD_ERASE, FSPC_CMD_LOAD: cmd_legal = 1'b1; // [R22]
			default: cmd_legal = 1'b0;
		endcase
	end

	// EEPROM activity blocks arming, as does an operation already running
	assign ctrl_wr = bus_done && pwrite && ctrl_hit && cmd_legal && idle && !eeprom_busy; // [R22]

	// Arming windows
	logic store_win;
	logic load_win;
	logic store_take;
	logic load_fuse;

	assign store_take = store_program_instr && idle && store_win && st_ff.ctrl[FSPC_EN_BIT];
	assign load_fuse = load_program_instr && idle && load_win && st_ff.ctrl[FSPC_RFL_BIT]
		&& st_ff.ctrl[FSPC_EN_BIT] && !eeprom_busy; // [R16]

	fspc_window #(
		.LEN(FSPC_STORE_WIN)
	) u_store_win (
		.clk(core_clk),
		.rst_sync_b(rst_sync_ff),
		.start(ctrl_wr),
		.cancel(store_take),
		.active(store_win)
	);

	fspc_window #(
		.LEN(FSPC_LOAD_WIN)
	) u_load_win (
		.clk(core_clk),
		.rst_sync_b(rst_sync_ff),
		.start(ctrl_wr && pwdata[FSPC_RFL_BIT]),
		.cancel(load_fuse),
		.active(load_win)
	);

	// Pointer fields: bit 0 is the byte, then word-in-page, then page
	logic [WORD_BITS-1:0] ptr_word;
	logic [PAGE_W-1:0] ptr_page;

	assign ptr_word = pointer[WORD_BITS:1]; // [R10]
	assign ptr_page = pointer[15:WORD_BITS+1]; // [R10]

	// Page buffer
	logic buf_we;
	logic buf_clear;
	logic buf_any;
	logic write_done;
	logic [15:0] buf_rdata;

	assign buf_we = store_take && st_ff.ctrl == FSPC_CMD_LOAD; // [R4] [R12]
	assign write_done = st_ff.state == FSPC_WRITE && st_ff.timer == '0;
	assign buf_clear = (store_take && st_ff.ctrl == FSPC_CMD_CLEAR) // [R15]
		|| write_done // [R5]
		|| (eeprom_busy && buf_any && idle); // [R7]

	fspc_page_buf #(
		.WORD_BITS(WORD_BITS),
		.DATA_W(16)
	) u_page_buf (
		.clk(core_clk),
		.rst_sync_b(rst_sync_ff),
		.clear(buf_clear),
		.we(buf_we),
		.waddr(ptr_word),
		.wdata(data_register_pair),
		.raddr(st_ff.stream[WORD_BITS-1:0]),
		.rdata(buf_rdata),
		.any_valid(buf_any)
	);

	// Register read value
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (ctrl_hit) begin
			rd_val[4:0] = st_ff.ctrl; // [R14]
		end else if (stat_hit) begin
			rd_val[FSPC_STAT_BUSY_BIT] = st_ff.stall;
			rd_val[FSPC_STAT_BUFD_BIT] = buf_any;
			rd_val[FSPC_STAT_ARM_BIT] = store_win;
		end
	end

	// Next state of the whole controller
	always_comb begin
		nxt_st = st_ff;
		nxt_st.erase_go = 1'b0;
		nxt_st.prog_we = 1'b0;
		nxt_st.load_valid = 1'b0;

		// APB answer one cycle into the access phase
		nxt_st.pready = psel && penable && !st_ff.pready;
		if (psel && penable && !st_ff.pready) begin
			nxt_st.pslverr = !(ctrl_hit || stat_hit);
			nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			nxt_st.pslverr = 1'b0;
		end

		unique case (st_ff.state)
			FSPC_IDLE: begin
				if (ctrl_wr) begin
					nxt_st.ctrl = pwdata[4:0];
				end else if (store_take) begin
					if (st_ff.ctrl[FSPC_ERS_BIT]) begin
						// Data pair is not used; only the page is taken
						nxt_st.state = FSPC_ERASE; // [R2] [R19]
						nxt_st.page = ptr_page; // [R11]
						nxt_st.stall = 1'b1; // [R3]
						nxt_st.erase_go = 1'b1;
						nxt_st.timer = FSPC_TIMER_W'(PROG_CYCLES - 1); // [R23]
					end else if (st_ff.ctrl[FSPC_WRT_BIT]) begin
						// Non-page pointer bits are software's to keep at zero
						nxt_st.state = FSPC_WRITE; // [R8] [R17]
						nxt_st.page = ptr_page; // [R11]
						nxt_st.stall = 1'b1; // [R9]
						nxt_st.stream = '0;
						nxt_st.timer = FSPC_TIMER_W'(PROG_CYCLES - 1); // [R23]
					end else begin
						// Load or clear finishes with the instruction itself
						nxt_st.ctrl = 5'h00; // [R21]
					end
				end else if (load_fuse) begin
					nxt_st.load_valid = 1'b1;
					nxt_st.ctrl = 5'h00; // [R16]
					if (pointer[0]) begin
						nxt_st.load_data = pointer[1] ? fuse_high : lock_bits; // [R16]
					end else begin
						nxt_st.load_data = fuse_low; // [R16]
					end
				end else begin
					if (load_program_instr) begin
						nxt_st.load_valid = 1'b1;
						nxt_st.load_data = pointer[0] ? flash_rd_word[15:8] : flash_rd_word[7:0]; // [R13]
					end
					// Unused arming lapses when its window runs out
					if (!store_win) begin
						nxt_st.ctrl = 5'h00; // [R18] [R20] [R21]
					end else if (st_ff.ctrl[FSPC_RFL_BIT] && !load_win) begin
						nxt_st.ctrl = 5'h00; // [R16]
					end
				end
			end
			FSPC_ERASE: begin
				if (st_ff.timer == '0) begin
					// Stall and command bits drop on the same edge
					nxt_st.state = FSPC_IDLE;
					nxt_st.stall = 1'b0; // [R3] [R24]
					nxt_st.ctrl = 5'h00; // [R20] [R21] [R24]
				end else begin
					nxt_st.timer = st_ff.timer - FSPC_TIMER_W'(1);
				end
			end
			FSPC_WRITE: begin
				// Buffer words stream out to the array at the start of the write
				if (st_ff.stream < (WORD_BITS+1)'(WORDS)) begin
					nxt_st.prog_we = 1'b1; // [R9]
					nxt_st.prog_word = st_ff.stream[WORD_BITS-1:0];
					nxt_st.prog_data = buf_rdata;
					nxt_st.stream = st_ff.stream + (WORD_BITS+1)'(1);
				end
				if (st_ff.timer == '0) begin
					nxt_st.state = FSPC_IDLE;
					nxt_st.stall = 1'b0; // [R9] [R24]
					nxt_st.ctrl = 5'h00; // [R18] [R21] [R24]
				end else begin
					nxt_st.timer = st_ff.timer - FSPC_TIMER_W'(1);
				end
			end
			default: begin
				// Illegal code: drop state, stall and command bits back to idle
				nxt_st.state = FSPC_IDLE;
				nxt_st.stall = 1'b0;
				nxt_st.ctrl = 5'h00;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			st_ff <= '0;
			st_ff.state <= FSPC_IDLE;
			st_ff.ctrl <= FSPC_CTRL_RESET[4:0];
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign load_data = st_ff.load_data;
	assign load_valid = st_ff.load_valid;
	assign core_stall = st_ff.stall;
	assign flash_page = st_ff.page;
	assign flash_erase_start = st_ff.erase_go;
	assign flash_prog_we = st_ff.prog_we;
	assign flash_prog_word = st_ff.prog_word;
	assign flash_prog_data = st_ff.prog_data;
endmodule : fspc_ctrl

// >>> sim/fspc_ctrl_asserts.sv
// Port checker of the flash self-programming controller
`timescale 1ns/1ps
module fspc_ctrl_asserts import fspc_pkg::*; #(
	parameter int WORD_BITS = 5,
	parameter int PROG_CYCLES = 50
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Core side
	input wire logic store_program_instr,
	input wire logic load_program_instr,
	input wire logic load_valid,
	input wire logic core_stall,
	// Flash side
	input wire logic [15-WORD_BITS-1:0] flash_page,
	input wire logic flash_erase_start,
	input wire logic flash_prog_we,
	input wire logic [WORD_BITS-1:0] flash_prog_word
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [31:0] stall_cnt_ff;
	logic [31:0] nxt_stall_cnt;
	// Stall length, restarts at zero so back-to-back operations are timed apart
	assign nxt_stall_cnt = core_stall ? stall_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) stall_cnt_ff <= 32'h0000_0000;
		else stall_cnt_ff <= nxt_stall_cnt;
	end
	// Erase must stream nothing into the array during its first nine cycles
	sequence s_erase_quiet;
		!flash_prog_we ##1 (!flash_prog_we) [*8];
	endsequence
	sequence s_prog_head;
		flash_prog_we && core_stall && flash_prog_word == '0;
	endsequence
	AST_ERASE_STALLS: assert property (flash_erase_start |-> core_stall)
		else $error("erase start without stall");
	AST_STALL_CAUSE: assert property ($rose(core_stall) |-> $past(store_program_instr))
		else $error("stall without store instruction");
	// Stall stands exactly the programmed cycle count; the counter is read before it restarts
	AST_STALL_LEN: assert property ($fell(core_stall) |-> stall_cnt_ff == PROG_CYCLES)
		else $error("stall length wrong");
	AST_PROG_HEAD: assert property ($rose(flash_prog_we) |-> s_prog_head)
		else $error("program stream start wrong");
	AST_PROG_STEP: assert property (flash_prog_we && flash_prog_word != '1
		|=> flash_prog_we && flash_prog_word == $past(flash_prog_word) + 1'b1)
		else $error("program stream gap");
	AST_ERASE_NO_PROG: assert property (flash_erase_start |-> s_erase_quiet)
		else $error("erase wrote words");
	AST_LOAD_ANSWER: assert property (1'b1 |-> load_valid == $past(load_program_instr))
		else $error("load answer timing wrong");
	AST_CTRL_RSV: assert property (pready && !pwrite && paddr == FSPC_CTRL_OFFS |-> prdata[31:5] == '0)
		else $error("reserved control bits set");
	AST_ARMED_IN_OP: assert property (pready && !pwrite && paddr == FSPC_CTRL_OFFS && core_stall
		&& $past(core_stall) |-> prdata[FSPC_EN_BIT])
		else $error("enable dropped during operation");
	AST_PAGE_STABLE: assert property (core_stall && $past(core_stall) |-> $stable(flash_page))
		else $error("page moved during operation");
endmodule : fspc_ctrl_asserts

bind fspc_ctrl fspc_ctrl_asserts #(.WORD_BITS(WORD_BITS), .PROG_CYCLES(PROG_CYCLES)) u_fspc_chk (.*);

// >>> sim/fspc_core_model.sv
// Processor core model issuing store and load program instructions
`timescale 1ns/1ps
module fspc_core_model #(
	parameter logic [7:0] LOCK_VAL = 8'hFC,
	parameter logic [7:0] FUSE_LO_VAL = 8'h62,
	parameter logic [7:0] FUSE_HI_VAL = 8'hDF
) (
	// Clock
	input wire logic core_clk,
	// Instruction side
	output logic store_program_instr,
	output logic load_program_instr,
	output logic [15:0] pointer,
	output logic [15:0] data_register_pair,
	output logic [15:0] flash_rd_word,
	input wire logic [7:0] load_data,
	input wire logic load_valid,
	// Fuse, lock and EEPROM
	output logic [7:0] lock_bits,
	output logic [7:0] fuse_low,
	output logic [7:0] fuse_high,
	output logic eeprom_busy
);
	// Fixed fuse contents; flash image is a plain function of the address
	assign lock_bits = LOCK_VAL;
	assign fuse_low = FUSE_LO_VAL;
	assign fuse_high = FUSE_HI_VAL;
	assign flash_rd_word = pointer ^ 16'h5A3C;
	initial begin
		store_program_instr = 1'b0;
		load_program_instr = 1'b0;
		pointer = 16'h0000;
		data_register_pair = 16'h0000;
		eeprom_busy = 1'b0;
	end
	// One-cycle store; released lines show the inverse so stale values never match
	task do_store(input logic [15:0] p, input logic [15:0] d);
		pointer <= p;
		data_register_pair <= d;
		store_program_instr <= 1'b1;
		@(posedge core_clk);
		store_program_instr <= 1'b0;
		pointer <= ~p;
		data_register_pair <= ~d;
	endtask : do_store
	// Load answer is taken one cycle after the pulse
	task do_load(input logic [15:0] p, output logic [7:0] q);
		pointer <= p;
		load_program_instr <= 1'b1;
		@(posedge core_clk);
		load_program_instr <= 1'b0;
		pointer <= ~p;
		@(negedge core_clk);
		q = (load_valid === 1'b1) ? load_data : 8'hxx;
		@(posedge core_clk);
	endtask : do_load
	task eeprom_write();
		eeprom_busy <= 1'b1;
		repeat (2) @(posedge core_clk);
		eeprom_busy <= 1'b0;
	endtask : eeprom_write
endmodule : fspc_core_model

// >>> sim/fspc_ctrl_tb.sv
// Self-checking bench of the flash self-programming controller
`timescale 1ns/1ps
module fspc_ctrl_tb import fspc_pkg::*; ;
	localparam int PROG = 50;
	localparam logic [9:0] PAGE = 10'h2A5;
	localparam logic [7:0] LOCK_V = 8'hFC;
	localparam logic [7:0] FLO_V = 8'h62;
	localparam logic [7:0] FHI_V = 8'hDF;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, load_data, lock_bits, fuse_low, fuse_high, q;
	logic [31:0] pwdata, prdata, rd;
	logic store_program_instr, load_program_instr, load_valid, core_stall, eeprom_busy;
	logic flash_erase_start, flash_prog_we;
	logic [15:0] pointer, data_register_pair, flash_rd_word, flash_prog_data;
	logic [9:0] flash_page;
	logic [4:0] flash_prog_word;
	logic [15:0] img [32];
	logic [15:0] exp_img [32];
	int bad_count, checks_done, cycles;
	fspc_ctrl #(.PROG_CYCLES(PROG)) DUT (.*);
	fspc_core_model #(.LOCK_VAL(LOCK_V), .FUSE_LO_VAL(FLO_V), .FUSE_HI_VAL(FHI_V)) core (.*);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Array image capture and hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (flash_prog_we === 1'b1) img[flash_prog_word] <= flash_prog_data;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// APB master: holds the request until pready is seen high at a rising edge
	// One idle edge follows, so a second call never re-raises psel in the same step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk("register read", rd, exp);
	endtask : rd_chk
	task clr_exp();
		foreach (exp_img[i]) exp_img[i] = 16'hFFFF;
	endtask : clr_exp
	task ld(input logic [4:0] w, input logic [15:0] d);
		apb(1'b1, FSPC_CTRL_OFFS, 32'h0000_0001);
		core.do_store({PAGE, w, 1'b0}, d);
		exp_img[w] = d;
	endtask : ld
	task wait_stall(input logic lvl);
		int i;
		@(negedge core_clk);
		for (i = 0; i < 100 && core_stall !== lvl; i++) @(negedge core_clk);
		chk("core_stall", {31'h0, core_stall}, {31'h0, lvl});
		@(posedge core_clk);
	endtask : wait_stall
	// Erase or write of the fixed page, stalled core, self-clearing command
	task op(input logic [31:0] cmd);
		apb(1'b1, FSPC_CTRL_OFFS, cmd);
		core.do_store({PAGE, 6'h00}, 16'hBEEF);
		wait_stall(1'b1);
		rd_chk(FSPC_CTRL_OFFS, cmd);
		wait_stall(1'b0);
		rd_chk(FSPC_CTRL_OFFS, 32'h0000_0000);
		chk("flash_page", {22'h0, flash_page}, {22'h0, PAGE});
	endtask : op
	task t_regs();
		logic [31:0] bad [5];
		logic [31:0] good [5];
		bad = '{32'h07, 32'h1F, 32'h0D, 32'h02, 32'h15};
		good = '{32'h11, 32'h09, 32'h05, 32'h03, 32'h01};
		rd_chk(FSPC_CTRL_OFFS, {24'h0, FSPC_CTRL_RESET});
		rd_chk(FSPC_STAT_OFFS, 32'h0000_0000);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("unmapped error", {31'h0, er}, 32'h0000_0001);
		apb(1'b1, FSPC_CTRL_OFFS, 32'h0000_00E1);
		rd_chk(FSPC_CTRL_OFFS, 32'h0000_0001);
		foreach (bad[i]) begin
			apb(1'b1, FSPC_CTRL_OFFS, bad[i]);
			rd_chk(FSPC_CTRL_OFFS, 32'h0000_0000);
		end
		// Late store after each window lapses must do nothing
		foreach (good[i]) begin
			apb(1'b1, FSPC_CTRL_OFFS, good[i]);
			rd_chk(FSPC_CTRL_OFFS, good[i]);
			repeat (4) @(posedge core_clk);
			core.do_store({PAGE, 6'h02}, 16'h1234);
			rd_chk(FSPC_CTRL_OFFS, 32'h0000_0000);
			rd_chk(FSPC_STAT_OFFS, 32'h0000_0000);
		end
	endtask : t_regs
	task t_buffer();
		ld(5'd9, 16'h1111);
		ld(5'd2, 16'h2222);
		rd_chk(FSPC_STAT_OFFS, 32'h0000_0002);
		apb(1'b1, FSPC_CTRL_OFFS, 32'h0000_0011);
		core.do_store(16'h0000, 16'h0000);
		rd_chk(FSPC_STAT_OFFS, 32'h0000_0000);
		ld(5'd3, 16'h3333);
		core.eeprom_write();
		rd_chk(FSPC_STAT_OFFS, 32'h0000_0000);
		ld(5'd4, 16'h4444);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd_chk(FSPC_STAT_OFFS, 32'h0000_0000);
		clr_exp();
	endtask : t_buffer
	task t_program();
		op(32'h0000_0003);
		ld(5'd31, 16'hA1A1);
		ld(5'd0, 16'hB2B2);
		ld(5'd17, 16'hC3C3);
		foreach (img[i]) img[i] = 16'hxxxx;
		op(32'h0000_0005);
		foreach (img[i]) chk("programmed word", {16'h0, img[i]}, {16'h0, exp_img[i]});
		rd_chk(FSPC_STAT_OFFS, 32'h0000_0000);
		clr_exp();
	endtask : t_program
	task t_fuse();
		logic [15:0] ptr [3];
		logic [7:0] val [3];
		ptr = '{16'h0000, 16'h0001, 16'h0003};
		val = '{FLO_V, LOCK_V, FHI_V};
		foreach (ptr[i]) begin
			apb(1'b1, FSPC_CTRL_OFFS, 32'h0000_0009);
			core.do_load(ptr[i], q);
			chk("fuse read", {24'h0, q}, {24'h0, val[i]});
		end
		core.do_load(16'h1235, q);
		chk("high byte", {24'h0, q}, {24'h0, 8'h12 ^ 8'h5A});
		core.do_load(16'h1234, q);
		chk("low byte", {24'h0, q}, {24'h0, 8'h34 ^ 8'h3C});
	endtask : t_fuse
	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		bad_count = 0;
		checks_done = 0;
		cycles = 0;
		clr_exp();
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_regs();
		t_buffer();
		t_program();
		t_fuse();
		report_and_stop();
	end
endmodule : fspc_ctrl_tb
